// ### usb_interrupt_gating.sv
// USB interrupt enable, mode-dependent bit 0 gating and priority register.
//
// Functional notes
// - enable bits 31..8 read zero, ignore writes
// - bit 7 gates handshake-stall event
// - bit 6 gates attach event
// - bit 4 gates bus-idle event
// - bit 3 gates token-done flag
// - bit 2 gates start-of-frame flag
// - bit 1 gates USB error
// - device mode, bit 0 gates bus reset
// - host mode, bit 0 gates detach
// - error reaches request only when enabled
// - priority 1..7, code zero disables source
// - subpriority code 0..3 stored directly
// - clear, set, invert aliases at 4, 8, c
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module usb_interrupt_gating (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst,
    // Register port.
    input  wire logic [15:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // Event pulses from the USB core.
    input  wire logic        stall_event,
    input  wire logic        attach_event,
    input  wire logic        resume_event,
    input  wire logic        bus_quiet_event,
    input  wire logic        token_done_event,
    input  wire logic        frame_start_event,
    input  wire logic        usb_error_event,
    input  wire logic        bus_reset_event,
    input  wire logic        detach_event,
    // Interrupt request and its ranking.
    output logic             usb_combined_irq_flag,
    output logic             irq,
    output logic      [2:0]  usb_irq_priority,
    output logic      [1:0]  usb_irq_subpriority
);
    // Internal state. Every event latches a sticky flag that software
    // clears by writing ones to the clear register; an event that lands
    // in the clear cycle wins, so no event is lost to a racing clear.
    // Bit 0 of the enable register gates bus reset in device mode and
    // detach in host mode, chosen by the mode register. The priority
    // register stores every source's fields for software, but only the
    // USB fields drive the rank outputs. Its alias addresses only take
    // writes and read as zero, so software must read the base address.
    logic [7:0]  usb_event_irq_enable;
    logic [31:0] irq_priority_ctrl_7;
    logic        host_mode;
    logic [8:0]  flags;
    logic [8:0]  set_vec;
    logic [8:0]  clr_vec;
    logic [7:0]  gated;
    logic        any_pending;
    logic [31:0] next_prio;
    logic [31:0] next_rdata;
    logic [15:0] prio_off;

    // Event inputs in flag order; index 8 holds detach.
    assign set_vec = {detach_event, stall_event, attach_event, resume_event,
                      bus_quiet_event, token_done_event, frame_start_event,
                      usb_error_event, bus_reset_event};
    // A write of one to the clear register drops a flag.
    assign clr_vec = (wr && addr == usb_irq_pkg::CLEAR_ADDR)
                     ? wdata[8:0] : 9'h000;

    // One sticky flag per event source.
    genvar g;
    generate
        for (g = 0; g < 9; g++) begin : gen_flag
            sticky_flag u_flag (
                .mclk (mclk),
                .rst  (rst),
                .set  (set_vec[g]),
                .clr  (clr_vec[g]),
                .flag (flags[g])
            );
        end
    endgenerate

    // Flags hold until cleared, and a set in the clear cycle is kept.
    a_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
        !(wr && addr == usb_irq_pkg::CLEAR_ADDR)
        |=> (flags & $past(flags)) == $past(flags))
        else $error("flag dropped without a clear");
    a_set_wins: assert property (@(posedge mclk) disable iff (rst)
        set_vec != 9'h000
        |=> (flags & $past(set_vec)) == $past(set_vec))
        else $error("event did not set its flag");
    a_clear_drop: assert property (@(posedge mclk) disable iff (rst)
        set_vec == 9'h000 && clr_vec != 9'h000
        |=> (flags & $past(clr_vec)) == 9'h000)
        else $error("clear did not drop its flag");

    // Enable and mode registers; upper write bits are dropped.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            usb_event_irq_enable <= usb_irq_pkg::ENABLE_RST;
            host_mode            <= 1'b0;
        end else if (wr && addr == usb_irq_pkg::ENABLE_ADDR) begin
            usb_event_irq_enable <= wdata[7:0];
        end else if (wr && addr == usb_irq_pkg::MODE_ADDR) begin
            host_mode <= wdata[0];
        end
    end

    // Enable and mode writes land in one edge; enables hold otherwise.
    a_enable_write: assert property (@(posedge mclk) disable iff (rst)
        wr && addr == usb_irq_pkg::ENABLE_ADDR
        |=> usb_event_irq_enable == $past(wdata[7:0]))
        else $error("enable write lost");
    a_enable_hold: assert property (@(posedge mclk) disable iff (rst)
        !(wr && addr == usb_irq_pkg::ENABLE_ADDR)
        |=> $stable(usb_event_irq_enable))
        else $error("enable changed without a write");
    a_mode_write: assert property (@(posedge mclk) disable iff (rst)
        wr && addr == usb_irq_pkg::MODE_ADDR
        |=> host_mode == $past(wdata[0]))
        else $error("mode write lost");

    // Priority register update through plain and alias addresses.
    always_comb begin
        prio_off  = addr - usb_irq_pkg::PRIORITY_ADDR;
        next_prio = irq_priority_ctrl_7;
        if (wr) begin
            case (prio_off)
                16'h0000: next_prio = wdata;
                usb_irq_pkg::ALIAS_CLR: next_prio = next_prio & ~wdata;
                usb_irq_pkg::ALIAS_SET: next_prio = next_prio | wdata;
                usb_irq_pkg::ALIAS_INV: next_prio = next_prio ^ wdata;
                default: next_prio = irq_priority_ctrl_7;
            endcase
        end
        next_prio = next_prio & usb_irq_pkg::PRIO_MASK;
    end

    // Priority register storage.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_priority_ctrl_7 <= usb_irq_pkg::PRIO_RST;
        end else begin
            irq_priority_ctrl_7 <= next_prio;
        end
    end

    // Priority register writes and the implemented field mask.
    a_plain_write: assert property (@(posedge mclk) disable iff (rst)
        wr && addr == usb_irq_pkg::PRIORITY_ADDR
        |=> irq_priority_ctrl_7 == ($past(wdata) & usb_irq_pkg::PRIO_MASK))
        else $error("priority write lost");
    a_inv_alias: assert property (@(posedge mclk) disable iff (rst)
        wr && addr == usb_irq_pkg::PRIORITY_ADDR + usb_irq_pkg::ALIAS_INV
        |=> irq_priority_ctrl_7 == (($past(irq_priority_ctrl_7)
            ^ $past(wdata)) & usb_irq_pkg::PRIO_MASK))
        else $error("invert alias failed");
    a_prio_hold: assert property (@(posedge mclk) disable iff (rst)
        !wr |=> $stable(irq_priority_ctrl_7))
        else $error("priority changed without a write");
    a_mask_bits: assert property (@(posedge mclk) disable iff (rst)
        (irq_priority_ctrl_7 & ~usb_irq_pkg::PRIO_MASK) == 32'h00000000)
        else $error("unimplemented priority bit set");

    // Per-source gating with the mode-dependent meaning of bit 0.
    always_comb begin
        gated = flags[7:0] & usb_event_irq_enable;
        gated[usb_irq_pkg::RESET_BIT] = host_mode
            ? (flags[8] & usb_event_irq_enable[0])
            : (flags[0] & usb_event_irq_enable[0]);
        any_pending = |gated;
    end

    // Each enabled flag reaches the combined request one edge later.
    a_attach_gate: assert property (@(posedge mclk) disable iff (rst)
        flags[6] && usb_event_irq_enable[6] |=> usb_combined_irq_flag)
        else $error("attach not propagated");
    a_resume_gate: assert property (@(posedge mclk) disable iff (rst)
        flags[5] && usb_event_irq_enable[5] |=> usb_combined_irq_flag)
        else $error("resume not propagated");
    a_quiet_gate: assert property (@(posedge mclk) disable iff (rst)
        flags[4] && usb_event_irq_enable[4] |=> usb_combined_irq_flag)
        else $error("bus idle not propagated");
    a_token_gate: assert property (@(posedge mclk) disable iff (rst)
        flags[3] && usb_event_irq_enable[3] |=> usb_combined_irq_flag)
        else $error("token done not propagated");
    a_frame_gate: assert property (@(posedge mclk) disable iff (rst)
        flags[2] && usb_event_irq_enable[2] |=> usb_combined_irq_flag)
        else $error("frame start not propagated");
    a_error_gate: assert property (@(posedge mclk) disable iff (rst)
        flags[1] && usb_event_irq_enable[1] |=> usb_combined_irq_flag)
        else $error("error not propagated");
    a_stall_block: assert property (@(posedge mclk) disable iff (rst)
        flags == 9'h080 && !usb_event_irq_enable[7] |=> !usb_combined_irq_flag)
        else $error("stall propagated while disabled");
    a_frame_block: assert property (@(posedge mclk) disable iff (rst)
        flags == 9'h004 && !usb_event_irq_enable[2] |=> !usb_combined_irq_flag)
        else $error("frame start propagated while disabled");
    a_device_detach: assert property (@(posedge mclk) disable iff (rst)
        !host_mode && flags == 9'h100 |=> !usb_combined_irq_flag)
        else $error("detach propagated in device mode");
    a_host_reset: assert property (@(posedge mclk) disable iff (rst)
        host_mode && flags == 9'h001 |=> !usb_combined_irq_flag)
        else $error("bus reset propagated in host mode");
    a_detach_block: assert property (@(posedge mclk) disable iff (rst)
        host_mode && flags == 9'h100 && !usb_event_irq_enable[0]
        |=> !usb_combined_irq_flag)
        else $error("detach propagated while disabled");
    a_any_request: assert property (@(posedge mclk) disable iff (rst)
        gated != 8'h00 |=> usb_combined_irq_flag)
        else $error("enabled flag without request");
    a_request_drop: assert property (@(posedge mclk) disable iff (rst)
        usb_event_irq_enable == 8'h00 |=> !usb_combined_irq_flag)
        else $error("request with every enable clear");

    // Request, line and rank outputs from flip-flops.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            usb_combined_irq_flag <= 1'b0;
            irq                   <= 1'b0;
            usb_irq_priority      <= 3'h0;
            usb_irq_subpriority   <= 2'h0;
        end else begin
            usb_combined_irq_flag <= any_pending;
            irq <= any_pending &&
                   next_prio[usb_irq_pkg::PRIO_LSB +: 3]
                   != usb_irq_pkg::PRIO_OFF;
            usb_irq_priority    <= next_prio[usb_irq_pkg::PRIO_LSB +: 3];
            usb_irq_subpriority <= next_prio[usb_irq_pkg::SUB_LSB +: 2];
        end
    end

    // The line follows the request only while the rank is nonzero.
    a_irq_rank: assert property (@(posedge mclk) disable iff (rst)
        irq == (usb_combined_irq_flag
                && usb_irq_priority != usb_irq_pkg::PRIO_OFF))
        else $error("irq does not follow request and rank");
    a_prio_copy: assert property (@(posedge mclk) disable iff (rst)
        usb_irq_priority == irq_priority_ctrl_7[usb_irq_pkg::PRIO_LSB +: 3])
        else $error("priority output stale");
    a_reset_clear: assert property (@(posedge mclk)
        $fell(rst) |-> usb_event_irq_enable == usb_irq_pkg::ENABLE_RST
            && irq_priority_ctrl_7 == usb_irq_pkg::PRIO_RST
            && !usb_combined_irq_flag && !irq)
        else $error("state not cleared by reset");

    // Read data mux; unmapped addresses and aliases read zero.
    always_comb begin
        next_rdata = 32'h00000000;
        case (addr)
            usb_irq_pkg::ENABLE_ADDR:
                next_rdata = {24'h000000, usb_event_irq_enable};
            usb_irq_pkg::STATUS_ADDR:   next_rdata = {23'h0, flags};
            usb_irq_pkg::MODE_ADDR:     next_rdata = {31'h0, host_mode};
            usb_irq_pkg::PRIORITY_ADDR: next_rdata = irq_priority_ctrl_7;
            default:                    next_rdata = 32'h00000000;
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= rd ? next_rdata : 32'h00000000;
        end
    end

    // Read data stand one cycle and aliases read as zero.
    a_rdata_idle: assert property (@(posedge mclk) disable iff (rst)
        !rd |=> rdata == 32'h00000000)
        else $error("read data outside a read");
    a_enable_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == usb_irq_pkg::ENABLE_ADDR
        |=> rdata == {24'h0, $past(usb_event_irq_enable)})
        else $error("enable read wrong");
    a_prio_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == usb_irq_pkg::PRIORITY_ADDR
        |=> rdata == $past(irq_priority_ctrl_7))
        else $error("priority read wrong");
    a_alias_read: assert property (@(posedge mclk) disable iff (rst)
        rd && (addr == usb_irq_pkg::PRIORITY_ADDR + usb_irq_pkg::ALIAS_CLR
            || addr == usb_irq_pkg::PRIORITY_ADDR + usb_irq_pkg::ALIAS_SET
            || addr == usb_irq_pkg::PRIORITY_ADDR + usb_irq_pkg::ALIAS_INV)
        |=> rdata == 32'h00000000)
        else $error("alias read not zero");
    a_status_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == usb_irq_pkg::STATUS_ADDR
        |=> rdata == {23'h0, $past(flags)})
        else $error("status read wrong");

    // Checks on the gating and register behaviour.
    a_upper_zero: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == usb_irq_pkg::ENABLE_ADDR |=> rdata[31:8] == 24'h0)
        else $error("enable upper bits not zero");
    a_stall_gate: assert property (@(posedge mclk) disable iff (rst)
        flags[7] && usb_event_irq_enable[7] |=> usb_combined_irq_flag)
        else $error("stall not propagated");
    a_error_block: assert property (@(posedge mclk) disable iff (rst)
        flags[7:0] == 8'h02 && !usb_event_irq_enable[1] && !host_mode
        |=> !usb_combined_irq_flag)
        else $error("error propagated while disabled");
    a_device_reset: assert property (@(posedge mclk) disable iff (rst)
        !host_mode && flags[0] && usb_event_irq_enable[0]
        |=> usb_combined_irq_flag)
        else $error("bus reset not propagated");
    a_host_detach: assert property (@(posedge mclk) disable iff (rst)
        host_mode && flags[8] && usb_event_irq_enable[0]
        |=> usb_combined_irq_flag)
        else $error("detach not propagated");
    a_prio_off: assert property (@(posedge mclk) disable iff (rst)
        usb_irq_priority == 3'h0 |-> !irq)
        else $error("irq with priority zero");
    a_set_alias: assert property (@(posedge mclk) disable iff (rst)
        wr && addr == usb_irq_pkg::PRIORITY_ADDR + usb_irq_pkg::ALIAS_SET
        |=> (irq_priority_ctrl_7 & $past(wdata) & usb_irq_pkg::PRIO_MASK)
            == ($past(wdata) & usb_irq_pkg::PRIO_MASK))
        else $error("set alias failed");
    a_clr_alias: assert property (@(posedge mclk) disable iff (rst)
        wr && addr == usb_irq_pkg::PRIORITY_ADDR + usb_irq_pkg::ALIAS_CLR
        |=> (irq_priority_ctrl_7 & $past(wdata)) == 32'h0)
        else $error("clear alias failed");
    a_sub_track: assert property (@(posedge mclk) disable iff (rst)
        ##1 usb_irq_subpriority
            == irq_priority_ctrl_7[usb_irq_pkg::SUB_LSB +: 2])
        else $error("subpriority mismatch");
    a_no_request: assert property (@(posedge mclk) disable iff (rst)
        gated == 8'h00 |=> !usb_combined_irq_flag)
        else $error("request without enabled flag");

    // Main scenarios.
    c_irq_raised: cover property (@(posedge mclk) disable iff (rst)
        !irq ##1 irq);
    c_host_detach: cover property (@(posedge mclk) disable iff (rst)
        host_mode && gated[0]);
    c_inv_alias: cover property (@(posedge mclk) disable iff (rst)
        wr && addr == usb_irq_pkg::PRIORITY_ADDR + usb_irq_pkg::ALIAS_INV);
    c_clr_alias: cover property (@(posedge mclk) disable iff (rst)
        wr && addr == usb_irq_pkg::PRIORITY_ADDR + usb_irq_pkg::ALIAS_CLR);
    c_top_rank: cover property (@(posedge mclk) disable iff (rst)
        irq && usb_irq_priority == 3'h7);
endmodule

// ### usb_irq_pkg.sv
// Package holding register offsets, field layouts and reset values.
package usb_irq_pkg;
    // Register byte addresses.
    localparam logic [15:0] ENABLE_ADDR   = 16'h1000;
    localparam logic [15:0] STATUS_ADDR   = 16'h1010;
    localparam logic [15:0] CLEAR_ADDR    = 16'h1020;
    localparam logic [15:0] MODE_ADDR     = 16'h1030;
    localparam logic [15:0] PRIORITY_ADDR = 16'h1100;
    // Alias offsets: clear, set and invert.
    localparam logic [15:0] ALIAS_CLR = 16'h0004;
    localparam logic [15:0] ALIAS_SET = 16'h0008;
    localparam logic [15:0] ALIAS_INV = 16'h000c;
    // Enable register field positions.
    localparam int STALL_BIT  = 7;
    localparam int ATTACH_BIT = 6;
    localparam int RESUME_BIT = 5;
    localparam int QUIET_BIT  = 4;
    localparam int TOKEN_BIT  = 3;
    localparam int FRAME_BIT  = 2;
    localparam int ERROR_BIT  = 1;
    localparam int RESET_BIT  = 0;
    localparam int EVENTS     = 8;
    // Priority register field positions for the USB source.
    localparam int PRIO_LSB = 18;
    localparam int SUB_LSB  = 16;
    // Implemented bits of the priority register.
    localparam logic [31:0] PRIO_MASK   = 32'h1f1f1f1f;
    localparam logic [7:0]  ENABLE_RST  = 8'h00;
    localparam logic [31:0] PRIO_RST    = 32'h00000000;
    localparam logic [2:0]  PRIO_OFF    = 3'h0;
endpackage

// ### sticky_flag.sv
// Sticky event flag where a set wins over a clear.
`timescale 1ns/1ps
module sticky_flag (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst,
    // Set and clear.
    input  wire logic set,
    input  wire logic clr,
    // Flag.
    output logic      flag
);
    // The flag holds until cleared; a set in the clear cycle is kept.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clr) begin
            flag <= 1'b0;
        end
    end
endmodule

// ### usb_interrupt_gating_bench.sv
// Self-checking bench for the USB interrupt gating block.
`timescale 1ns/1ps
module usb_interrupt_gating_bench;
    logic        mclk;
    logic        rst;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [8:0]  ev;
    logic [31:0] rdata;
    logic        combined;
    logic        irq;
    logic [2:0]  prio_o;
    logic [1:0]  sub_o;
    int          error_cnt;
    int          samples_checked;
    int          seed;
    int          i;
    int          k;
    int          m_en;
    int          m_st;
    int          m_prio;
    int          m_mode;
    int          m_rank;
    int          m_sub;

    usb_interrupt_gating u_dut (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .stall_event(ev[7]), .attach_event(ev[6]),
        .resume_event(ev[5]), .bus_quiet_event(ev[4]),
        .token_done_event(ev[3]), .frame_start_event(ev[2]),
        .usb_error_event(ev[1]), .bus_reset_event(ev[0]),
        .detach_event(ev[8]), .usb_combined_irq_flag(combined), .irq(irq),
        .usb_irq_priority(prio_o), .usb_irq_subpriority(sub_o)
    );

    // The clock toggles every half period of 5 ns.
    always #5 mclk = ~mclk;

    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string name);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task summarize();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Bit 0 gates bus reset in device mode and detach in host mode.
    function logic exp_comb();
        return ((m_st[7:1] & m_en[7:1]) != 0) ||
               (m_en[0] && (m_mode != 0 ? m_st[8] : m_st[0]));
    endfunction

    function logic [31:0] exp_rd(input logic [15:0] a);
        if (a == usb_irq_pkg::ENABLE_ADDR) return m_en;
        if (a == usb_irq_pkg::STATUS_ADDR) return m_st;
        if (a == usb_irq_pkg::PRIORITY_ADDR) return m_prio;
        if (a == usb_irq_pkg::MODE_ADDR) return m_mode;
        return 32'h00000000;
    endfunction

    // One write cycle, then the model takes the same write.
    task wr_reg(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        case (a)
            usb_irq_pkg::ENABLE_ADDR: m_en = d[7:0];
            usb_irq_pkg::CLEAR_ADDR: m_st = m_st & ~d[8:0];
            usb_irq_pkg::MODE_ADDR: m_mode = d[0];
            usb_irq_pkg::PRIORITY_ADDR: m_prio = d & usb_irq_pkg::PRIO_MASK;
            usb_irq_pkg::PRIORITY_ADDR + usb_irq_pkg::ALIAS_CLR:
                m_prio = m_prio & ~d;
            usb_irq_pkg::PRIORITY_ADDR + usb_irq_pkg::ALIAS_SET:
                m_prio = m_prio | (d & usb_irq_pkg::PRIO_MASK);
            usb_irq_pkg::PRIORITY_ADDR + usb_irq_pkg::ALIAS_INV:
                m_prio = m_prio ^ (d & usb_irq_pkg::PRIO_MASK);
            default: ;
        endcase
    endtask

    // One read cycle; the data stand only in the following cycle.
    task rd_reg(input logic [15:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check(rdata, exp_rd(a), "read data");
    endtask

    task pulse(input logic [8:0] m);
        @(posedge mclk);
        ev <= m;
        @(posedge mclk);
        ev <= 9'h000;
        m_st = m_st | m;
    endtask

    // Lets updates land, then compares every level output.
    task settle();
        repeat (2) @(posedge mclk);
        #1;
        m_rank = (m_prio >> usb_irq_pkg::PRIO_LSB) & 7;
        m_sub = (m_prio >> usb_irq_pkg::SUB_LSB) & 3;
        check(combined, exp_comb(), "combined flag");
        check(irq, exp_comb() && m_rank != 0, "irq");
        check(prio_o, m_rank, "priority");
        check(sub_o, m_sub, "subpriority");
    endtask

    // Main sequence: reset, per-event gating, then random traffic.
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        addr = 16'h0000;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
        ev = 9'h000;
        seed = 97;
        {m_en, m_st, m_prio, m_mode} = '0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(usb_irq_pkg::ENABLE_ADDR);
        rd_reg(usb_irq_pkg::PRIORITY_ADDR);
        wr_reg(usb_irq_pkg::ENABLE_ADDR, 32'hffffffff);
        rd_reg(usb_irq_pkg::ENABLE_ADDR);
        wr_reg(usb_irq_pkg::ENABLE_ADDR, 32'h00000000);
        for (i = 0; i < 9; i++) begin
            wr_reg(usb_irq_pkg::MODE_ADDR, 32'(i == 8));
            pulse(9'(1 << i));
            settle();
            wr_reg(usb_irq_pkg::ENABLE_ADDR, 32'(1 << (i % 8)));
            settle();
            rd_reg(usb_irq_pkg::STATUS_ADDR);
            wr_reg(usb_irq_pkg::CLEAR_ADDR, 32'h000001ff);
            settle();
        end
        for (i = 0; i < 120; i++) begin
            k = $random(seed) & 7;
            case (k)
                0: wr_reg(usb_irq_pkg::ENABLE_ADDR, $random(seed));
                1: pulse(9'($random(seed)));
                2: wr_reg(usb_irq_pkg::CLEAR_ADDR, $random(seed));
                3: wr_reg(usb_irq_pkg::MODE_ADDR, $random(seed));
                4: wr_reg(usb_irq_pkg::PRIORITY_ADDR +
                          16'(($random(seed) & 3) << 2), $random(seed));
                5: rd_reg(usb_irq_pkg::STATUS_ADDR);
                6: rd_reg(usb_irq_pkg::PRIORITY_ADDR +
                          16'(($random(seed) & 3) << 2));
                default: begin
                    wr_reg(usb_irq_pkg::ENABLE_ADDR, $random(seed));
                    rd_reg(usb_irq_pkg::ENABLE_ADDR);
                    rd_reg(16'h1040);
                    rd_reg(usb_irq_pkg::MODE_ADDR);
                end
            endcase
            settle();
        end
        summarize();
    end

    // Cuts a hung run short and counts it as a mismatch.
    initial begin
        #500000;
        error_cnt++;
        summarize();
    end
endmodule
